//--- core/ccva_top.sv
// Counter and capture/compare value access block on a classic Wishbone slave port.
`timescale 1ns/1ps

module ccva_top
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave.
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ccva_pkg::CCVA_ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [ccva_pkg::CCVA_DAT_W-1:0] dat_i,
    output logic [ccva_pkg::CCVA_DAT_W-1:0] dat_o,
    output logic ack_o,
    // Compare results per module.
    output ccva_pkg::ccva_out_t cmp_o
);
    import ccva_pkg::*;

    // The index tables are sized for three modules and eight-bit indices; other sizes cannot be decoded.
    if (CCVA_NMOD != $size(CCVA_IDX_CMP_LO))
    begin
        $error("Module count does not match the index tables.");
    end
    if (CCVA_ADR_W - CCVA_IDX_LSB != $bits(CCVA_IDX_CNT_LO))
    begin
        $error("Address width must leave an eight-bit register index.");
    end
    if (CCVA_DAT_W < $bits(CCVA_RST_BYTE))
    begin
        $error("Data bus must carry at least one byte.");
    end

    ccva_state_t st_reg;
    ccva_state_t st_next;
    logic req;
    logic wr;
    logic rd;
    logic ars;
    logic [7:0] idx;
    logic [7:0] wdat;
    logic [7:0] rval;
    logic [1:0] psize;

    // Mask of the low bits that take part in an 8 to 11-bit PWM period.
    function automatic logic [15:0] pwm_mask(input logic [1:0] size);
        logic [4:0] bits;
        bits = 5'(CCVA_BASE_PWM_BITS) + {3'h0, size};
        pwm_mask = (CCVA_ONE16 << bits) - CCVA_ONE16;
    endfunction

    // Mask that applies to module m in its present mode.
    function automatic logic [15:0] mod_mask(input logic [7:0] mode, input logic [1:0] size);
        mod_mask = 16'hFFFF;
        if (mode[CCVA_MODE_PWM] && !mode[CCVA_MODE_W16])
        begin
            mod_mask = pwm_mask(size);
        end
    endfunction

    assign req = cyc_i && stb_i && !st_reg.ack;
    assign wr = req && we_i && sel_i[0];
    assign rd = req && !we_i;
    assign idx = adr_i[CCVA_ADR_W-1:CCVA_IDX_LSB];
    assign wdat = dat_i[7:0];
    assign ars = st_reg.pwmcfg[CCVA_CFG_ARS];
    assign psize = st_reg.pwmcfg[CCVA_CFG_SIZE_LSB +: 2];

    // Read multiplexer; an unmapped index answers zero.
    always_comb
    begin
        rval = CCVA_RST_BYTE;
        if (idx == CCVA_IDX_CNT_LO)
        begin
            rval = st_reg.cnt[7:0];
        end
        if (idx == CCVA_IDX_CNT_HI)
        begin
            rval = st_reg.snap;
        end
        if (idx == CCVA_IDX_CTRL)
        begin
            rval = {7'h00, st_reg.run};
        end
        if (idx == CCVA_IDX_PWMCFG)
        begin
            rval = st_reg.pwmcfg;
        end
        for (int m = 0; m < CCVA_NMOD; m++)
        begin
            if (idx == CCVA_IDX_CMP_LO[m])
            begin
                rval = ars ? st_reg.arl[m][7:0] : st_reg.cmp[m][7:0];
            end
            if (idx == CCVA_IDX_CMP_HI[m])
            begin
                rval = ars ? st_reg.arl[m][15:8] : st_reg.cmp[m][15:8];
            end
            if (idx == CCVA_IDX_MODE[m])
            begin
                rval = st_reg.mode[m];
            end
        end
    end

    always_comb
    begin
        st_next = st_reg;
        st_next.ack = req;
        st_next.rdata = rd ? rval : CCVA_RST_BYTE;
        if (st_reg.run)
        begin
            st_next.cnt = st_reg.cnt + CCVA_ONE16;
        end
        // Snapshot keeps the high byte coherent with the low byte just read.
        if (rd && idx == CCVA_IDX_CNT_LO)
        begin
            st_next.snap = st_reg.cnt[15:8];
        end
        // Auto-reload at the end of each 9 to 11-bit PWM period.
        for (int m = 0; m < CCVA_NMOD; m++)
        begin
            if (st_reg.mode[m][CCVA_MODE_PWM] && !st_reg.mode[m][CCVA_MODE_W16] && psize != CCVA_SIZE_8BIT
                && (st_reg.cnt & pwm_mask(psize)) == pwm_mask(psize))
            begin
                st_next.cmp[m] = st_reg.arl[m];
            end
        end
        // Bus writes win over counting and reload in the same cycle.
        if (wr)
        begin
            if (idx == CCVA_IDX_CNT_LO)
            begin
                st_next.cnt[7:0] = wdat;
            end
            if (idx == CCVA_IDX_CNT_HI)
            begin
                st_next.cnt[15:8] = wdat;
            end
            if (idx == CCVA_IDX_CTRL)
            begin
                st_next.run = wdat[CCVA_CTRL_RUN];
            end
            if (idx == CCVA_IDX_PWMCFG)
            begin
                st_next.pwmcfg = wdat;
            end
            for (int m = 0; m < CCVA_NMOD; m++)
            begin
                if (idx == CCVA_IDX_MODE[m])
                begin
                    st_next.mode[m] = wdat;
                end
                if (idx == CCVA_IDX_CMP_LO[m])
                begin
                    if (ars)
                    begin
                        st_next.arl[m][7:0] = wdat;
                    end
                    else
                    begin
                        st_next.cmp[m][7:0] = wdat;
                    end
                    st_next.mode[m][CCVA_MODE_CEN] = 1'b0;
                end
                if (idx == CCVA_IDX_CMP_HI[m])
                begin
                    if (ars)
                    begin
                        st_next.arl[m][15:8] = wdat;
                    end
                    else
                    begin
                        st_next.cmp[m][15:8] = wdat;
                    end
                    st_next.mode[m][CCVA_MODE_CEN] = 1'b1;
                end
            end
        end
        // Compare outputs; a disabled comparator holds both low.
        for (int m = 0; m < CCVA_NMOD; m++)
        begin
            st_next.match[m] = st_reg.mode[m][CCVA_MODE_CEN]
                && (st_reg.cnt & mod_mask(st_reg.mode[m], psize))
                == (st_reg.cmp[m] & mod_mask(st_reg.mode[m], psize));
            st_next.pwm[m] = st_reg.mode[m][CCVA_MODE_CEN] && st_reg.mode[m][CCVA_MODE_PWM]
                && (st_reg.cnt & mod_mask(st_reg.mode[m], psize))
                >= (st_reg.cmp[m] & mod_mask(st_reg.mode[m], psize));
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign ack_o = st_reg.ack;
    assign dat_o = CCVA_DAT_W'(st_reg.rdata);
    assign cmp_o.match = st_reg.match;
    assign cmp_o.pwm = st_reg.pwm;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_CNT_LO_WRITE: assert property (wr && idx == CCVA_IDX_CNT_LO |=> st_reg.cnt[7:0] == $past(wdat))
        else $error("Counter low byte write lost.");
    AST_CNT_HI_WRITE: assert property (wr && idx == CCVA_IDX_CNT_HI |=> st_reg.cnt[15:8] == $past(wdat))
        else $error("Counter high byte write lost.");
    AST_SNAP_LOAD: assert property (rd && idx == CCVA_IDX_CNT_LO |=> st_reg.snap == $past(st_reg.cnt[15:8]))
        else $error("Snapshot not loaded on low byte read.");
    AST_SNAP_HOLD: assert property (!(rd && idx == CCVA_IDX_CNT_LO) |=> $stable(st_reg.snap))
        else $error("Snapshot changed without low byte read.");
    AST_HI_READ: assert property (rd && idx == CCVA_IDX_CNT_HI |=> ack_o && dat_o[7:0] == st_reg.snap)
        else $error("High byte read does not return snapshot.");
    AST_CMP_LO_WRITE: assert property (wr && !ars && idx == CCVA_IDX_CMP_LO[0]
        |=> st_reg.cmp[0][7:0] == $past(wdat) && !st_reg.mode[0][CCVA_MODE_CEN])
        else $error("Compare low write failed.");
    AST_CMP_HI_WRITE: assert property (wr && !ars && idx == CCVA_IDX_CMP_HI[1]
        |=> st_reg.cmp[1][15:8] == $past(wdat))
        else $error("Compare high write failed.");
    AST_ARL_LO_WRITE: assert property (wr && ars && idx == CCVA_IDX_CMP_LO[2]
        |=> st_reg.arl[2][7:0] == $past(wdat))
        else $error("Reload low write failed.");
    AST_ARL_HI_KEEP: assert property (wr && ars && idx == CCVA_IDX_CMP_HI[0]
        && !st_reg.mode[0][CCVA_MODE_PWM]
        |=> st_reg.arl[0][15:8] == $past(wdat) && $stable(st_reg.cmp[0]))
        else $error("Reload high write touched the compare value.");
    AST_CEN_CLEAR: assert property (wr && idx == CCVA_IDX_CMP_LO[1] |=> !st_reg.mode[1][CCVA_MODE_CEN])
        else $error("Comparator enable not cleared.");
    AST_CEN_SET: assert property (wr && idx == CCVA_IDX_CMP_HI[2] |=> st_reg.mode[2][CCVA_MODE_CEN])
        else $error("Comparator enable not set.");
    AST_CEN_GATE: assert property (!st_reg.mode[0][CCVA_MODE_CEN] |=> !cmp_o.match[0] && !cmp_o.pwm[0])
        else $error("Disabled comparator still active.");
    AST_MATCH16: assert property (st_reg.mode[0][CCVA_MODE_CEN] && st_reg.mode[0][CCVA_MODE_W16]
        && st_reg.cnt == st_reg.cmp[0] |=> cmp_o.match[0])
        else $error("16-bit match missed.");
    AST_ACK_ONE: assert property (ack_o |=> !ack_o)
        else $error("Ack held longer than one cycle.");

    // Bus answer, side effects and counting.
    AST_ACK_RESP: assert property (req
        |=> ack_o)
        else $error("Request not answered in the next cycle.");
    AST_RDATA_IDLE: assert property (!ack_o
        |-> dat_o == '0)
        else $error("Read data not zero outside the answer cycle.");
    AST_CNT_LO_READ: assert property (rd && idx == CCVA_IDX_CNT_LO
        |=> ack_o && dat_o[7:0] == $past(st_reg.cnt[7:0]))
        else $error("Counter low byte read wrong.");
    AST_CNT_STEP: assert property (st_reg.run && !wr
        |=> st_reg.cnt == $past(st_reg.cnt) + CCVA_ONE16)
        else $error("Running counter did not advance by one.");
    AST_REFUSED_WRITE: assert property (req && we_i && !sel_i[0]
        |=> $stable(st_reg.arl) && $stable(st_reg.mode) && $stable(st_reg.pwmcfg) && $stable(st_reg.run))
        else $error("Write without byte enable changed a register.");
    AST_RD_NO_SIDE: assert property (rd
        |=> $stable(st_reg.arl) && $stable(st_reg.mode) && $stable(st_reg.pwmcfg) && $stable(st_reg.run))
        else $error("Read changed a register.");
    AST_CTRL_WRITE: assert property (wr && idx == CCVA_IDX_CTRL
        |=> st_reg.run == $past(wdat[CCVA_CTRL_RUN]))
        else $error("Run bit write lost.");
    AST_PWMCFG_WRITE: assert property (wr && idx == CCVA_IDX_PWMCFG
        |=> st_reg.pwmcfg == $past(wdat))
        else $error("Configuration write lost.");

    // Every module keeps the same byte, enable and compare rules; one loop keeps them alike.
    for (genvar g = 0; g < CCVA_NMOD; g++)
    begin
        AST_MOD_LO_STORE: assert property (@(posedge clk_i) disable iff (rst_i)
            wr && !ars && idx == CCVA_IDX_CMP_LO[g]
            |=> st_reg.cmp[g][7:0] == $past(wdat) && !st_reg.mode[g][CCVA_MODE_CEN])
            else $error("Compare low byte store failed.");
        AST_MOD_HI_STORE: assert property (@(posedge clk_i) disable iff (rst_i)
            wr && !ars && idx == CCVA_IDX_CMP_HI[g]
            |=> st_reg.cmp[g][15:8] == $past(wdat) && st_reg.mode[g][CCVA_MODE_CEN])
            else $error("Compare high byte store failed.");
        AST_MOD_ARL_LO: assert property (@(posedge clk_i) disable iff (rst_i)
            wr && ars && idx == CCVA_IDX_CMP_LO[g]
            |=> st_reg.arl[g][7:0] == $past(wdat) && !st_reg.mode[g][CCVA_MODE_CEN])
            else $error("Reload low byte store failed.");
        AST_MOD_ARL_HI: assert property (@(posedge clk_i) disable iff (rst_i)
            wr && ars && idx == CCVA_IDX_CMP_HI[g]
            |=> st_reg.arl[g][15:8] == $past(wdat) && st_reg.mode[g][CCVA_MODE_CEN])
            else $error("Reload high byte store failed.");
        AST_MOD_LO_READ: assert property (@(posedge clk_i) disable iff (rst_i)
            rd && idx == CCVA_IDX_CMP_LO[g]
            |=> dat_o[7:0] == $past(ars ? st_reg.arl[g][7:0] : st_reg.cmp[g][7:0]))
            else $error("Low byte read took the wrong value.");
        AST_MOD_HI_READ: assert property (@(posedge clk_i) disable iff (rst_i)
            rd && idx == CCVA_IDX_CMP_HI[g]
            |=> dat_o[7:0] == $past(ars ? st_reg.arl[g][15:8] : st_reg.cmp[g][15:8]))
            else $error("High byte read took the wrong value.");
        AST_MOD_MODE_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
            wr && idx == CCVA_IDX_MODE[g]
            |=> st_reg.mode[g] == $past(wdat))
            else $error("Mode write lost.");
        AST_MOD_MODE_READ: assert property (@(posedge clk_i) disable iff (rst_i)
            rd && idx == CCVA_IDX_MODE[g]
            |=> dat_o[7:0] == $past(st_reg.mode[g]))
            else $error("Mode read wrong.");
        AST_MOD_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
            !st_reg.mode[g][CCVA_MODE_CEN]
            |=> !cmp_o.match[g] && !cmp_o.pwm[g])
            else $error("Disabled comparator still active.");
        AST_MOD_PWM_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
            !st_reg.mode[g][CCVA_MODE_PWM]
            |=> !cmp_o.pwm[g])
            else $error("PWM output active outside PWM mode.");
        AST_MOD_MATCH16: assert property (@(posedge clk_i) disable iff (rst_i)
            st_reg.mode[g][CCVA_MODE_CEN] && st_reg.mode[g][CCVA_MODE_W16] && st_reg.cnt == st_reg.cmp[g]
            |=> cmp_o.match[g])
            else $error("Full-width match missed.");
        AST_MOD_RELOAD: assert property (@(posedge clk_i) disable iff (rst_i)
            st_reg.mode[g][CCVA_MODE_PWM] && !st_reg.mode[g][CCVA_MODE_W16] && psize != CCVA_SIZE_8BIT
            && &(st_reg.cnt | ~pwm_mask(psize)) && !wr
            |=> st_reg.cmp[g] == $past(st_reg.arl[g]))
            else $error("Reload value not applied at the end of the period.");
    end

endmodule

//--- inc/ccva_pkg.sv
// Package holding register indices, field positions and state layout of the counter and compare access block.
package ccva_pkg;

    localparam int CCVA_NMOD = 3;
    localparam int CCVA_ADR_W = 10;
    localparam int CCVA_DAT_W = 32;
    localparam int CCVA_IDX_LSB = 2;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] CCVA_IDX_CNT_LO = 8'hF9;
    localparam logic [7:0] CCVA_IDX_CNT_HI = 8'hFA;
    localparam logic [7:0] CCVA_IDX_CTRL = 8'hD8;
    localparam logic [7:0] CCVA_IDX_PWMCFG = 8'hF7;
    localparam logic [2:0][7:0] CCVA_IDX_CMP_LO = {8'hEB, 8'hE9, 8'hFB};
    localparam logic [2:0][7:0] CCVA_IDX_CMP_HI = {8'hEC, 8'hEA, 8'hFC};
    localparam logic [2:0][7:0] CCVA_IDX_MODE = {8'hDC, 8'hDB, 8'hDA};

    // Field positions and the base PWM width.
    localparam int CCVA_MODE_W16 = 7;
    localparam int CCVA_MODE_CEN = 6;
    localparam int CCVA_MODE_PWM = 1;
    localparam int CCVA_CFG_ARS = 7;
    localparam int CCVA_CFG_SIZE_LSB = 0;
    localparam int CCVA_CTRL_RUN = 0;
    localparam int CCVA_BASE_PWM_BITS = 8;

    // Reset values, count step and the 8-bit size code.
    localparam logic [7:0] CCVA_RST_BYTE = 8'h00;
    localparam logic [15:0] CCVA_RST_WORD = 16'h0000;
    localparam logic [15:0] CCVA_ONE16 = 16'h0001;
    localparam logic [1:0] CCVA_SIZE_8BIT = 2'h0;

    typedef struct packed {
        logic ack;
        logic [7:0] rdata;
        logic run;
        logic [15:0] cnt;
        logic [7:0] snap;
        logic [7:0] pwmcfg;
        logic [CCVA_NMOD-1:0][15:0] cmp;
        logic [CCVA_NMOD-1:0][15:0] arl;
        logic [CCVA_NMOD-1:0][7:0] mode;
        logic [CCVA_NMOD-1:0] match;
        logic [CCVA_NMOD-1:0] pwm;
    } ccva_state_t;

    typedef struct packed {
        logic [CCVA_NMOD-1:0] match;
        logic [CCVA_NMOD-1:0] pwm;
    } ccva_out_t;

endpackage

//--- verification/ccva_top_tb.sv
// Self-checking bench for the counter and compare value access block.
`timescale 1ns/1ps

module ccva_top_tb;
    import ccva_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [CCVA_ADR_W-1:0] adr_i = '0;
    logic [3:0] sel_i = 4'hF;
    logic [CCVA_DAT_W-1:0] dat_i = '0;
    logic [CCVA_DAT_W-1:0] dat_o;
    logic ack_o;
    ccva_out_t cmp_o;
    logic [7:0] exp_q[$];
    logic [16:0] seed = 17'h109FF;
    logic [7:0] a;
    logic [7:0] b;
    logic [15:0] cv [0:2];
    logic [7:0] ridx [0:8] = '{8'hF9, 8'hFA, 8'hFB, 8'hFC, 8'hE9, 8'hEA, 8'hEB, 8'hEC, 8'h10};
    int bad_count = 0;
    int total_checks = 0;

    ccva_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .cmp_o(cmp_o));

    initial forever #12.5 clk_i = ~clk_i;

    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction

    task automatic test_done;
        if (bad_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %0t read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %0t compare output %b expected %b", $time, got, exp);
        end
    endtask

    // Ack is sampled at the rising edge; the request is dropped at that same edge, never earlier.
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic s0);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {idx, 2'b00};
        sel_i <= {4{s0}};
        dat_i <= {24'h5A5A5A, d};
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'b1 && n < 50);
        if (ack_o !== 1'b1)
        begin
            bad_count++;
            $display("MISMATCH %0t no acknowledge", $time);
            test_done();
        end
        else
        begin
            cyc_i <= 1'b0;
            stb_i <= 1'b0;
            we_i <= 1'b0;
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        wb(1'b1, idx, d, 1'b1);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        exp_q.push_back(e);
        wb(1'b0, idx, 8'h00, 1'b1);
    endtask

    task automatic settle_flag;
        repeat (3) @(negedge clk_i);
    endtask

    // Read results are taken at the rising edge of the answer, against the oldest noted expectation.
    always @(posedge clk_i)
    begin
        if (ack_o === 1'b1 && cyc_i === 1'b1 && we_i === 1'b0)
        begin
            if (exp_q.size() == 0)
                chk_rd(dat_o, 32'hFFFFFFFF);
            else
                chk_rd(dat_o, {24'h000000, exp_q.pop_front()});
        end
    end

    initial
    begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        $display("MISMATCH %0t run did not finish", $time);
        test_done();
    end

    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 9; i++)
            rd(ridx[i], 8'h00);
        seed = lfsr(seed);
        a = seed[7:0];
        seed = lfsr(seed);
        b = seed[7:0];
        wr(CCVA_IDX_CNT_LO, a);
        wr(CCVA_IDX_CNT_HI, b);
        rd(CCVA_IDX_CNT_HI, 8'h00);
        rd(CCVA_IDX_CNT_LO, a);
        rd(CCVA_IDX_CNT_HI, b);
        wr(CCVA_IDX_CNT_HI, ~b);
        rd(CCVA_IDX_CNT_HI, b);
        wb(1'b1, CCVA_IDX_CNT_LO, ~a, 1'b0);
        rd(CCVA_IDX_CNT_LO, a);
        for (int m = 0; m < 3; m++)
        begin
            seed = lfsr(seed);
            cv[m] = seed[15:0];
            wr(CCVA_IDX_CMP_LO[m], cv[m][7:0]);
            wr(CCVA_IDX_CMP_HI[m], cv[m][15:8]);
            rd(CCVA_IDX_CMP_LO[m], cv[m][7:0]);
            rd(CCVA_IDX_CMP_HI[m], cv[m][15:8]);
        end
        wr(CCVA_IDX_PWMCFG, 8'h80);
        for (int m = 0; m < 3; m++)
        begin
            wr(CCVA_IDX_CMP_LO[m], ~cv[m][7:0]);
            wr(CCVA_IDX_CMP_HI[m], ~cv[m][15:8]);
            rd(CCVA_IDX_CMP_LO[m], ~cv[m][7:0]);
            rd(CCVA_IDX_CMP_HI[m], ~cv[m][15:8]);
        end
        wr(CCVA_IDX_PWMCFG, 8'h00);
        for (int m = 0; m < 3; m++)
        begin
            rd(CCVA_IDX_CMP_LO[m], cv[m][7:0]);
            rd(CCVA_IDX_CMP_HI[m], cv[m][15:8]);
            rd(CCVA_IDX_MODE[m], 8'h40);
            wr(CCVA_IDX_CMP_LO[m], cv[m][7:0]);
            rd(CCVA_IDX_MODE[m], 8'h00);
        end
        // The counter is stopped, so the compare outputs hold still once set.
        wr(CCVA_IDX_CNT_LO, cv[1][7:0]);
        wr(CCVA_IDX_CNT_HI, cv[1][15:8]);
        settle_flag();
        chk_flag(cmp_o.match[1], 1'b0);
        wr(CCVA_IDX_CMP_HI[1], cv[1][15:8]);
        settle_flag();
        chk_flag(cmp_o.match[1], 1'b1);
        wr(CCVA_IDX_CMP_LO[1], cv[1][7:0]);
        settle_flag();
        chk_flag(cmp_o.match[1], 1'b0);
        wr(CCVA_IDX_CNT_LO, 8'h34);
        wr(CCVA_IDX_CNT_HI, 8'h12);
        wr(CCVA_IDX_MODE[0], 8'h02);
        wr(CCVA_IDX_CMP_LO[0], 8'h00);
        wr(CCVA_IDX_CMP_HI[0], 8'h13);
        settle_flag();
        chk_flag(cmp_o.pwm[0], 1'b1);
        wr(CCVA_IDX_MODE[0], 8'hC2);
        settle_flag();
        chk_flag(cmp_o.pwm[0], 1'b0);
        wr(CCVA_IDX_CNT_LO, 8'h00);
        wr(CCVA_IDX_CNT_HI, 8'h13);
        settle_flag();
        chk_flag(cmp_o.match[0], 1'b1);
        chk_flag(cmp_o.pwm[0], 1'b1);
        // One cycle to answer and one idle cycle give exactly three counting edges between the run writes.
        wr(CCVA_IDX_CNT_LO, 8'hFE);
        wr(CCVA_IDX_CNT_HI, 8'h00);
        wr(CCVA_IDX_CTRL, 8'h01);
        wr(CCVA_IDX_CTRL, 8'h00);
        rd(CCVA_IDX_CNT_LO, 8'h01);
        rd(CCVA_IDX_CNT_HI, 8'h01);
        test_done();
    end
endmodule
